// ---- logic/flash_prot_consts.svh ----
`ifndef FLASH_PROT_CONSTS_SVH
`define FLASH_PROT_CONSTS_SVH
// Register indices on the plain register port
`define REG_FLASH_ADDR 4'h0
`define REG_FLASH_DATA 4'h1
`define REG_FLASH_CTRL 4'h2
`define REG_READ_EN 4'h3
`define REG_PROG_EN 4'h4
`define REG_USEC 4'h5
`define REG_STATUS 4'h6
`define REG_INT_MASK 4'h7
`define REG_STATUS_CLR 4'h8
// Control bits of the flash control register
`define CTRL_WRITE_BIT 0
`define CTRL_ERASE_BIT 1
`define CTRL_COMMIT_BIT 3
// Status bits
`define STAT_BUSY_BIT 0
`define STAT_PVIOL_BIT 1
`define STAT_RVIOL_BIT 2
// Debug access field sits at the top of the read-enable word
`define DBG_HI 31
`define DBG_LO 30
`define DBG_OPEN 2'h2
// Commit select value for the debug field
`define COMMIT_DBG_ADDR 15'h0900
// Reset values
`define USEC_RESET 8'h31
`define PROT_FACTORY 32'h0000_ffff
`define ERASED_WORD 32'hffff_ffff
// Bit-band arithmetic: byte offset times 32, bit number times 4
`define BB_BYTE_SHIFT 5
`define BB_BIT_SHIFT 2
// Flash geometry
`define PROT_UNIT_SHIFT 11
`define ERASE_UNIT_SHIFT 10
`endif

// ---- logic/flash_prot_pkg.sv ----
package flash_prot_pkg;
  // Flash operation state
  typedef enum logic [1:0] {op_idle, op_tick, op_done} op_state_t;
  // Kind of requester on the access port
  typedef enum logic [1:0] {acc_data, acc_fetch, acc_debug} acc_kind_t;
endpackage

// ---- logic/bitband_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_consts.svh"
// Bit-band alias to byte address and bit number
module bitband_decode
  import flash_prot_pkg::*;
#(
  parameter int AW = 20
)(
  // Alias offset in
  input wire logic [AW-1:0] alias_off_i,
  // Decoded target
  output logic [AW-6:0] byte_off_o,
  output logic [2:0] bit_num_o
);
  // Inverse of base + byte*32 + bit*4
  assign byte_off_o = alias_off_i[AW-1:`BB_BYTE_SHIFT];
  assign bit_num_o = alias_off_i[`BB_BYTE_SHIFT-1:`BB_BIT_SHIFT];
endmodule
`default_nettype wire

// ---- logic/prot_check.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_consts.svh"
// Per-unit permission lookup for one requester
module prot_check
  import flash_prot_pkg::*;
#(
  parameter int AW = 15,
  parameter int UNITS = 16
)(
  // Request
  input wire logic [AW-1:0] addr_i,
  input wire acc_kind_t kind_i,
  // Protection words
  input wire logic [31:0] read_en_i,
  input wire logic [31:0] prog_en_i,
  // Verdicts
  output logic read_ok_o,
  output logic prog_ok_o
);
  logic [AW-`PROT_UNIT_SHIFT-1:0] unit; // 2-KB unit index
  logic in_range; // Index names an implemented unit
  assign unit = addr_i[AW-1:`PROT_UNIT_SHIFT];
  assign in_range = 32'(unit) < UNITS;
  // Fetch allowed in any implemented unit; data needs read enable
  assign read_ok_o = in_range && ((kind_i == acc_fetch) || read_en_i[unit]);
  // Modification needs program enable
  assign prog_ok_o = in_range && prog_en_i[unit];
endmodule
`default_nettype wire

// ---- logic/flash_protection_timing.sv ----
// Notes on behaviour
// - Alias word maps to single SRAM bit
// - Erase sets whole 1-KB unit to ones
// - Program only clears bits, never sets
// - Two 1-KB units share one bit pair
// - Read-only units refuse erase and program
// - Execute-only units serve only instruction fetch
// - Microsecond count is MHz minus one
// - Reload resets to fastest-clock value
// - Program enable one permits modification
// - Read enable zero leaves fetch only
// - Program-only unit refuses data reads
// - Blocked modification flags maskable violation
// - Blocked data read returns zeros
// - Factory state opens every unit
// - Protection writes act now, commit fixes
// - Uncommitted clears restored by power-on reset
// - Debug field 0x2 opens debug port
// - Debug disable takes effect next power-up
// - Cleared committed debug field returns only on por_i
// - Only debug port blocked, test port stays
// - Address bit 0 selects which word commits
// - Address 0x900 commits debug field
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_consts.svh"
module flash_protection_timing
  import flash_prot_pkg::*;
#(
  parameter int FLASH_WORDS = 8192,
  parameter int SRAM_WORDS = 2048,
  parameter int UNITS = 16
)(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic por_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Flash read port
  input wire logic flash_rd_i,
  input wire logic [14:0] flash_addr_i,
  input wire acc_kind_t flash_kind_i,
  output logic [31:0] flash_rdata_o,
  output logic flash_rvalid_o,
  // SRAM bit-band port
  input wire logic bb_wr_i,
  input wire logic bb_rd_i,
  input wire logic [20:0] bb_alias_i,
  input wire logic bb_wdata_i,
  output logic bb_rdata_o,
  // Debug access gate
  output logic debug_access_port_en_o,
  output logic test_port_en_o,
  // Violation event level
  output logic violation_o
);
  localparam int FAW = $clog2(FLASH_WORDS);
  localparam int SAW = $clog2(SRAM_WORDS);

  // Storage
  logic [31:0] flash_mem [FLASH_WORDS]; // Flash array
  logic [31:0] sram_mem [SRAM_WORDS]; // SRAM words
  // Registers
  logic [14:0] flash_address_reg_r; // Target address
  logic [31:0] flash_data_r; // Program data
  logic [31:0] read_enable_word_r; // Live read enables
  logic [31:0] program_enable_word_r; // Live program enables
  logic [31:0] read_commit_r; // Committed read enables
  logic [31:0] program_commit_r; // Committed program enables
  logic [7:0] usec_cycle_reload_r; // Cycles per microsecond minus one
  logic [2:0] flash_interrupt_mask_r; // Mask incl access_violation_mask
  logic pviol_r; // Program violation sticky
  logic rviol_r; // Read violation sticky
  logic dbg_open_r; // Debug gate sampled at power-up
  logic por_seen_r; // Power-up sample done
  // Operation engine
  op_state_t op_state_r;
  logic op_erase_r; // Erase versus program
  logic [7:0] usec_cnt_r; // Microsecond divider
  logic usec_tick; // One-cycle microsecond enable
  // Decoded requests
  logic ctrl_wr;
  logic start_prog;
  logic start_erase;
  logic start_commit;
  logic ctrl_ok;
  logic rd_ok;
  logic [SAW+2-1:0] bb_byte; // Byte offset from alias
  logic [2:0] bb_bit; // Bit number from alias
  logic [SAW-1:0] bb_word;
  logic [4:0] bb_pos;
  logic commit_dbg;
  logic [31:0] read_commit_nxt;

  assign ctrl_wr = reg_wr_i && (reg_addr_i == `REG_FLASH_CTRL);
  assign start_prog = ctrl_wr && reg_wdata_i[`CTRL_WRITE_BIT] && (op_state_r == op_idle);
  assign start_erase = ctrl_wr && reg_wdata_i[`CTRL_ERASE_BIT] && (op_state_r == op_idle);
  assign start_commit = ctrl_wr && reg_wdata_i[`CTRL_COMMIT_BIT];
  assign commit_dbg = flash_address_reg_r == `COMMIT_DBG_ADDR;

  // Permission for controller path
  prot_check #(.AW(15), .UNITS(UNITS)) u_ctrl_chk (
    .addr_i(flash_address_reg_r),
    .kind_i(acc_data),
    .read_en_i(read_enable_word_r),
    .prog_en_i(program_enable_word_r),
    .read_ok_o(),
    .prog_ok_o(ctrl_ok)
  );
  // Permission for core and debugger reads
  prot_check #(.AW(15), .UNITS(UNITS)) u_rd_chk (
    .addr_i(flash_addr_i),
    .kind_i(flash_kind_i),
    .read_en_i(read_enable_word_r),
    .prog_en_i(program_enable_word_r),
    .read_ok_o(rd_ok),
    .prog_ok_o()
  );
  // Alias decode
  bitband_decode #(.AW(SAW+7)) u_bb (
    .alias_off_i(bb_alias_i[SAW+6:0]),
    .byte_off_o(bb_byte),
    .bit_num_o(bb_bit)
  );
  assign bb_word = bb_byte[SAW+1:2];
  assign bb_pos = {bb_byte[1:0], bb_bit};

  // Address, data, mask registers
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      flash_address_reg_r <= '0;
      flash_data_r <= '0;
      flash_interrupt_mask_r <= '0;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == `REG_FLASH_ADDR)
        flash_address_reg_r <= reg_wdata_i[14:0];
      if (reg_addr_i == `REG_FLASH_DATA)
        flash_data_r <= reg_wdata_i;
      if (reg_addr_i == `REG_INT_MASK)
        flash_interrupt_mask_r <= reg_wdata_i[2:0];
    end
  end

  // Microsecond reload value
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      usec_cycle_reload_r <= `USEC_RESET;
    else if (reg_wr_i && reg_addr_i == `REG_USEC)
      usec_cycle_reload_r <= reg_wdata_i[7:0];
  end

  // Microsecond divider, runs only during operations
  always_ff @(posedge clk_i)
  begin
    if (reset_i || op_state_r == op_idle)
      usec_cnt_r <= usec_cycle_reload_r;
    else if (usec_cnt_r == 8'h00)
      usec_cnt_r <= usec_cycle_reload_r;
    else
      usec_cnt_r <= usec_cnt_r - 8'h01;
  end
  assign usec_tick = (op_state_r != op_idle) && (usec_cnt_r == 8'h00);

  // Commit: committed copy takes only clears; debug field one-way
  always_comb
  begin
    read_commit_nxt = read_commit_r;
    if (commit_dbg)
      read_commit_nxt = read_commit_r & read_enable_word_r;
    else if (!flash_address_reg_r[0])
      read_commit_nxt = {read_commit_r[31:30], read_commit_r[29:0] & read_enable_word_r[29:0]};
  end

  // Protection words, committed copies survive reset
  always_ff @(posedge clk_i)
  begin
    if (por_i)
    begin
      read_commit_r <= {`DBG_OPEN, 30'h0} | `PROT_FACTORY;
      program_commit_r <= `PROT_FACTORY;
    end
    else if (start_commit)
    begin
      read_commit_r <= read_commit_nxt;
      if (flash_address_reg_r[0] && !commit_dbg)
        program_commit_r <= program_commit_r & program_enable_word_r;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (por_i)
    begin
      read_enable_word_r <= {`DBG_OPEN, 30'h0} | `PROT_FACTORY;
      program_enable_word_r <= `PROT_FACTORY;
    end
    else if (reset_i)
    begin
      // Uncommitted changes fall back to committed copy
      read_enable_word_r <= read_commit_r;
      program_enable_word_r <= program_commit_r;
    end
    else if (reg_wr_i && reg_addr_i == `REG_READ_EN)
      // Live at once; committed debug clear cannot be undone
      read_enable_word_r <= reg_wdata_i & (read_commit_r | 32'h3fff_ffff);
    else if (reg_wr_i && reg_addr_i == `REG_PROG_EN)
      program_enable_word_r <= reg_wdata_i;
  end

  // Debug gate sampled once after power-up
  // Reset_i acts as a power cycle that keeps committed bits
  always_ff @(posedge clk_i)
  begin
    if (por_i || reset_i)
    begin
      por_seen_r <= 1'b0;
      dbg_open_r <= 1'b0;
    end
    else if (!por_seen_r)
    begin
      por_seen_r <= 1'b1;
      dbg_open_r <= read_commit_r[`DBG_HI:`DBG_LO] == `DBG_OPEN;
    end
  end
  always_ff @(posedge clk_i)
  begin
    debug_access_port_en_o <= dbg_open_r;
    test_port_en_o <= 1'b1;
  end

  // Operation engine: one microsecond per op
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      op_state_r <= op_idle;
      op_erase_r <= 1'b0;
    end
    else
    begin
      unique case (op_state_r)
        op_idle:
          if ((start_prog || start_erase) && ctrl_ok)
          begin
            op_state_r <= op_tick;
            op_erase_r <= start_erase;
          end
        op_tick:
          if (usec_tick)
            op_state_r <= op_done;
        op_done:
          op_state_r <= op_idle;
      endcase
    end
  end

  // Flash array update
  always_ff @(posedge clk_i)
  begin
    if (op_state_r == op_done)
    begin
      if (op_erase_r)
      begin
        for (int i = 0; i < FLASH_WORDS; i++)
          if ((i >> (`ERASE_UNIT_SHIFT - 2)) == (flash_address_reg_r >> `ERASE_UNIT_SHIFT))
            flash_mem[i] <= `ERASED_WORD;
      end
      else
        flash_mem[flash_address_reg_r[14:2]] <=
          flash_mem[flash_address_reg_r[14:2]] & flash_data_r;
    end
  end

  // Flash reads, zeros when blocked
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      flash_rdata_o <= '0;
      flash_rvalid_o <= 1'b0;
    end
    else
    begin
      flash_rvalid_o <= flash_rd_i;
      if (flash_rd_i)
        flash_rdata_o <= rd_ok ? flash_mem[flash_addr_i[14:2]] : '0;
    end
  end

  // Violation flags, set wins over clear
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pviol_r <= 1'b0;
      rviol_r <= 1'b0;
    end
    else
    begin
      if ((start_prog || start_erase) && !ctrl_ok)
        pviol_r <= 1'b1;
      else if (reg_wr_i && reg_addr_i == `REG_STATUS_CLR && reg_wdata_i[`STAT_PVIOL_BIT])
        pviol_r <= 1'b0;
      if (flash_rd_i && !rd_ok)
        rviol_r <= 1'b1;
      else if (reg_wr_i && reg_addr_i == `REG_STATUS_CLR && reg_wdata_i[`STAT_RVIOL_BIT])
        rviol_r <= 1'b0;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      violation_o <= 1'b0;
    else
      violation_o <= (pviol_r && flash_interrupt_mask_r[`STAT_PVIOL_BIT])
        || (rviol_r && flash_interrupt_mask_r[`STAT_RVIOL_BIT]);
  end

  // Bit-band SRAM single-bit access
  always_ff @(posedge clk_i)
  begin
    if (bb_wr_i)
      sram_mem[bb_word][bb_pos] <= bb_wdata_i;
  end
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      bb_rdata_o <= 1'b0;
    else if (bb_rd_i)
      bb_rdata_o <= sram_mem[bb_word][bb_pos];
  end

  // Register readback
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      reg_rdata_o <= '0;
    else if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        `REG_FLASH_ADDR: reg_rdata_o <= {17'h0, flash_address_reg_r};
        `REG_FLASH_DATA: reg_rdata_o <= flash_data_r;
        `REG_READ_EN: reg_rdata_o <= read_enable_word_r;
        `REG_PROG_EN: reg_rdata_o <= program_enable_word_r;
        `REG_USEC: reg_rdata_o <= {24'h0, usec_cycle_reload_r};
        `REG_STATUS: reg_rdata_o <= {29'h0, rviol_r, pviol_r, op_state_r != op_idle};
        `REG_INT_MASK: reg_rdata_o <= {29'h0, flash_interrupt_mask_r};
        default: reg_rdata_o <= '0;
      endcase
    end
  end

  // Blocked read never returns data
  property p_zero_on_block;
    @(posedge clk_i) disable iff (reset_i)
      (flash_rd_i && !rd_ok) |=> (flash_rdata_o == 32'h0);
  endproperty
  a_zero_on_block: assert property (p_zero_on_block) else $error("blocked read gave data");
  // Refused modification never starts
  property p_no_start;
    @(posedge clk_i) disable iff (reset_i)
      (op_state_r == op_idle && !ctrl_ok) |=> (op_state_r == op_idle);
  endproperty
  a_no_start: assert property (p_no_start) else $error("protected op started");
  // Refused program sets the flag
  property p_pviol;
    @(posedge clk_i) disable iff (reset_i)
      (start_prog && !ctrl_ok) |=> pviol_r;
  endproperty
  a_pviol: assert property (p_pviol) else $error("violation flag missing");
  // Reload resets to documented value
  property p_usec_reset;
    @(posedge clk_i) $fell(reset_i) |-> (usec_cycle_reload_r == `USEC_RESET);
  endproperty
  a_usec_reset: assert property (p_usec_reset) else $error("bad reload reset");
  // Operation lasts reload plus one cycles in tick
  property p_tick_len;
    @(posedge clk_i) disable iff (reset_i)
      (op_state_r == op_idle ##1 op_state_r == op_tick) |-> ##[0:256] usec_tick;
  endproperty
  a_tick_len: assert property (p_tick_len) else $error("microsecond tick missing");
  // Committed debug clear stays cleared
  property p_dbg_oneway;
    @(posedge clk_i) disable iff (por_i)
      (read_commit_r[`DBG_HI:`DBG_LO] != `DBG_OPEN) |=> (read_commit_r[`DBG_HI:`DBG_LO] != `DBG_OPEN);
  endproperty
  a_dbg_oneway: assert property (p_dbg_oneway) else $error("debug field restored");
  // Committed program-enable bits never go from zero to one
  property p_commit_clear_only;
    @(posedge clk_i) disable iff (por_i)
      1'b1 |=> ((program_commit_r & ~$past(program_commit_r)) == 32'h0);
  endproperty
  a_commit_clear_only: assert property (p_commit_clear_only) else $error("commit set a bit");
  // Test port always on
  property p_test_port;
    @(posedge clk_i) disable iff (reset_i) ##1 test_port_en_o;
  endproperty
  a_test_port: assert property (p_test_port) else $error("test port off");
endmodule
`default_nettype wire

// ---- testbench/core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Core side: data, fetch and debug flash reads plus bit-band accesses
module core_model
  import flash_prot_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Flash read port
  output logic flash_rd_o,
  output logic [14:0] flash_addr_o,
  output var acc_kind_t flash_kind_o,
  input wire logic [31:0] flash_rdata_i,
  input wire logic flash_rvalid_i,
  // Bit-band port
  output logic bb_wr_o,
  output logic bb_rd_o,
  output logic [20:0] bb_alias_o,
  output logic bb_wdata_o,
  input wire logic bb_rdata_i
);
  // Idle levels at time zero
  initial
  begin
    flash_rd_o = 1'b0;
    flash_addr_o = 15'h0000;
    flash_kind_o = acc_data;
    bb_wr_o = 1'b0;
    bb_rd_o = 1'b0;
    bb_alias_o = 21'h000000;
    bb_wdata_o = 1'b0;
  end
  // One flash read as data, fetch or debugger access
  task automatic flash_read(input acc_kind_t kind, input logic [14:0] addr,
                            output logic [31:0] data, output logic vld);
    @(posedge clk_i);
    flash_rd_o <= 1'b1;
    flash_addr_o <= addr;
    flash_kind_o <= kind;
    @(posedge clk_i);
    flash_rd_o <= 1'b0;
    // Released address flips so a stale value is never reused
    flash_addr_o <= ~addr;
    #1;
    data = flash_rdata_i;
    vld = flash_rvalid_i;
  endtask
  // One bit-band write or read, answer taken the cycle after
  task automatic bb_access(input logic wr, input logic [20:0] alias_off,
                           input logic wbit, output logic rbit);
    @(posedge clk_i);
    bb_wr_o <= wr;
    bb_rd_o <= ~wr;
    bb_alias_o <= alias_off;
    bb_wdata_o <= wbit;
    @(posedge clk_i);
    bb_wr_o <= 1'b0;
    bb_rd_o <= 1'b0;
    // Released lines flip
    bb_alias_o <= ~alias_off;
    bb_wdata_o <= ~wbit;
    #1;
    rbit = bb_rdata_i;
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_consts.svh"
// Self-checking bench with a behavioural protection model
module tb_top
  import flash_prot_pkg::*;
;
  // Clock, resets and register port
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic por_i = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  // Core side and status wires
  logic flash_rd, flash_rvalid, bb_wr, bb_rd, bb_wdata, bb_rdata;
  logic debug_en, test_en, viol;
  logic [14:0] flash_addr;
  logic [31:0] flash_rdata;
  logic [20:0] bb_alias;
  acc_kind_t flash_kind;
  // Score and model state
  int n_mismatch = 0;
  int checked = 0;
  int seed = 62;
  logic [31:0] flash_m [int];
  logic [31:0] re_m, pe_m, re_c, pe_c, stat_m, sram_m, d;
  logic [20:0] a;
  logic bit_seen;
  // Free-running clock
  always #20 clk_i = ~clk_i;
  // Design and core model
  flash_protection_timing #(.FLASH_WORDS(8192), .SRAM_WORDS(2048), .UNITS(16))
  i_flash_protection_timing (.clk_i(clk_i), .reset_i(reset_i), .por_i(por_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .flash_rd_i(flash_rd),
    .flash_addr_i(flash_addr), .flash_kind_i(flash_kind), .flash_rdata_o(flash_rdata),
    .flash_rvalid_o(flash_rvalid), .bb_wr_i(bb_wr), .bb_rd_i(bb_rd),
    .bb_alias_i(bb_alias), .bb_wdata_i(bb_wdata), .bb_rdata_o(bb_rdata),
    .debug_access_port_en_o(debug_en), .test_port_en_o(test_en), .violation_o(viol));
  core_model i_core_model (.clk_i(clk_i), .flash_rd_o(flash_rd),
    .flash_addr_o(flash_addr), .flash_kind_o(flash_kind), .flash_rdata_i(flash_rdata),
    .flash_rvalid_i(flash_rvalid), .bb_wr_o(bb_wr), .bb_rd_o(bb_rd),
    .bb_alias_o(bb_alias), .bb_wdata_o(bb_wdata), .bb_rdata_i(bb_rdata));
  // Compare and count
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Verdict and end of run
  task automatic give_verdict();
    if (n_mismatch == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Register bus write and read
  task automatic reg_write(input logic [3:0] ra, input logic [31:0] v);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= ra;
    reg_wdata_i <= v;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] ra, output logic [31:0] v);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= ra;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    v = reg_rdata_o;
  endtask
  task automatic reg_check(input string what, input logic [3:0] ra, input logic [31:0] exp);
    logic [31:0] v;
    reg_read(ra, v);
    check(what, exp, v);
  endtask
  // Start a flash operation, check busy, then wait for idle with a bound
  task automatic flash_op(input logic [14:0] fa, input logic [31:0] dat, input logic [31:0] ctl,
                          input logic busy_exp);
    logic [31:0] v;
    int n;
    reg_write(`REG_FLASH_ADDR, {17'h0, fa});
    reg_write(`REG_FLASH_DATA, dat);
    reg_write(`REG_FLASH_CTRL, ctl);
    reg_read(`REG_STATUS, v);
    check("busy", {31'h0, busy_exp}, {31'h0, v[`STAT_BUSY_BIT]});
    n = 0;
    while (v[`STAT_BUSY_BIT] !== 1'b0 && n < 300)
    begin
      reg_read(`REG_STATUS, v);
      n++;
    end
    // Busy never dropping counts as a mismatch
    if (n == 300)
      n_mismatch++;
    check("status", stat_m, v);
  endtask
  // Program or erase, with the model applying the program-enable word
  task automatic do_op(input logic [14:0] fa, input logic [31:0] dat, input logic erase);
    if (pe_m[fa[14:11]] !== 1'b1)
      stat_m[1] = 1'b1;
    else if (erase)
      for (int w = 0; w < 256; w++)
        flash_m[{fa[14:10], 10'h0} + w * 4] = `ERASED_WORD;
    else
      flash_m[fa] = flash_m[fa] & dat;
    flash_op(fa, dat, 32'h1 << (erase ? `CTRL_ERASE_BIT : `CTRL_WRITE_BIT), pe_m[fa[14:11]]);
  endtask
  // Flash read compared with the model; data and debug need read enable
  task automatic flash_check(input acc_kind_t k, input logic [14:0] fa);
    logic [31:0] v;
    logic ok;
    i_core_model.flash_read(k, fa, v, ok);
    if (k == acc_fetch || re_m[fa[14:11]] === 1'b1)
      check("flash_data", flash_m[fa], v);
    else
      check("flash_blocked", 32'h0, v);
    check("flash_valid", 32'h1, {31'h0, ok});
    if (k != acc_fetch && re_m[fa[14:11]] !== 1'b1)
      stat_m[2] = 1'b1;
  endtask
  // Resets: reset_i alone reloads committed words, por restores factory
  task automatic pulse_reset(input logic por);
    @(posedge clk_i);
    reset_i <= 1'b1;
    por_i <= por;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    por_i <= 1'b0;
    re_m = por ? 32'h8000ffff : re_c;
    pe_m = por ? `PROT_FACTORY : pe_c;
    stat_m = 32'h0;
  endtask
  // Level of the masked violation output
  task automatic viol_check();
    reg_check("status", `REG_STATUS, stat_m);
    check("violation", {31'h0, |stat_m[2:1]}, {31'h0, viol});
  endtask
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    give_verdict();
  end
  // Main sequence
  initial
  begin
    re_c = 32'h8000ffff;
    pe_c = `PROT_FACTORY;
    pulse_reset(1'b1);
    reg_check("read_en", `REG_READ_EN, re_m);
    reg_check("prog_en", `REG_PROG_EN, pe_m);
    reg_check("usec", `REG_USEC, {24'h0, `USEC_RESET});
    reg_check("unmapped", 4'h9, 32'h0);
    check("debug_port", 32'h1, {31'h0, debug_en});
    reg_write(`REG_USEC, 32'h13);
    reg_check("usec", `REG_USEC, 32'h13);
    reg_write(`REG_INT_MASK, 32'h6);
    do_op(15'h0800, 32'h0, 1'b1);
    do_op(15'h0c00, 32'h0, 1'b1);
    flash_check(acc_data, 15'h0ffc);
    for (int i = 0; i < 2; i++)
    begin
      d = $random(seed);
      do_op(15'h0800, d, 1'b0);
      flash_check(acc_data, 15'h0800);
    end
    re_m[1] = 1'b0;
    reg_write(`REG_READ_EN, re_m);
    flash_check(acc_data, 15'h0800);
    do_op(15'h0c00, $random(seed), 1'b0);
    flash_check(acc_fetch, 15'h0c00);
    viol_check();
    reg_write(`REG_STATUS_CLR, 32'h6);
    stat_m = 32'h0;
    viol_check();
    pe_m[1] = 1'b0;
    reg_write(`REG_PROG_EN, pe_m);
    do_op(15'h0c00, 32'h0, 1'b1);
    do_op(15'h0800, 32'h0, 1'b0);
    flash_check(acc_debug, 15'h0800);
    flash_check(acc_fetch, 15'h0800);
    flash_check(acc_fetch, 15'h0c00);
    viol_check();
    pulse_reset(1'b0);
    reg_check("read_en", `REG_READ_EN, re_m);
    reg_check("prog_en", `REG_PROG_EN, pe_m);
    reg_check("usec", `REG_USEC, {24'h0, `USEC_RESET});
    re_m[2] = 1'b0;
    reg_write(`REG_READ_EN, re_m);
    flash_op(15'h0000, 32'h0, 32'h1 << `CTRL_COMMIT_BIT, 1'b0);
    re_c[29:0] = re_c[29:0] & re_m[29:0];
    pe_m[3] = 1'b0;
    reg_write(`REG_PROG_EN, pe_m);
    flash_op(15'h0001, 32'h0, 32'h1 << `CTRL_COMMIT_BIT, 1'b0);
    pe_c = pe_c & pe_m;
    re_m[`DBG_HI:`DBG_LO] = 2'h0;
    // Read-enable bit 6 goes in the same commit as the debug clear
    re_m[6] = 1'b0;
    reg_write(`REG_READ_EN, re_m);
    flash_op(`COMMIT_DBG_ADDR, 32'h0, 32'h1 << `CTRL_COMMIT_BIT, 1'b0);
    re_c = re_c & re_m;
    check("debug_port", 32'h1, {31'h0, debug_en});
    pulse_reset(1'b0);
    reg_check("read_en", `REG_READ_EN, re_m);
    reg_check("prog_en", `REG_PROG_EN, pe_m);
    check("debug_port", 32'h0, {31'h0, debug_en});
    check("test_port", 32'h1, {31'h0, test_en});
    reg_write(`REG_READ_EN, re_m | 32'hc000_0000);
    reg_check("read_en", `REG_READ_EN, re_m);
    pe_m[5] = 1'b0;
    reg_write(`REG_PROG_EN, pe_m);
    pulse_reset(1'b1);
    reg_check("prog_en", `REG_PROG_EN, pe_m);
    for (int p = 0; p < 3; p++)
      for (int b = 0; b < 32; b++)
      begin
        a = 21'((12'h100 + b / 8) * 32 + (b % 8) * 4);
        if (p == 0 || (p == 1 && b == 5))
        begin
          sram_m[b] = (p == 0) ? 1'($random(seed)) : ~sram_m[b];
          i_core_model.bb_access(1'b1, a, sram_m[b], bit_seen);
        end
        else
        begin
          i_core_model.bb_access(1'b0, a, 1'b0, bit_seen);
          check("bb_bit", {31'h0, sram_m[b]}, {31'h0, bit_seen});
        end
      end
    give_verdict();
  end
endmodule
`default_nettype wire
